// ===== bench/lcdft_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module lcdft_chk
(
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [13:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        low_freq_osc_in,
  input wire logic        timer3_output_in,
  input wire logic [1:0]  gray_mode_in,
  input wire logic [23:0] cursor_address_bits_out,
  input wire logic [3:0]  pixel_offset_bits_out,
  input wire logic        line_pulse_out,
  input wire logic        frame_pulse_out,
  input wire logic        frame_polarity_out
);
  wire [11:0]  ix = paddr_in[13:2];
  wire         acc = psel_in && penable_in;
  wire         bad = !(ix inside {[12'h209:12'h20C], [12'h210:12'h214]});
  logic [23:0] ca_q, ca_d;
  logic [3:0]  pc_q, pc_d, pc_x;
  logic        inv, inv_d, inv_e;
  // Shadow of software writes; outputs may lag it by one register
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in)
    begin
      ca_q <= 24'h400000;
      ca_d <= 24'h400000;
      pc_q <= 4'h0;
      pc_d <= 4'h0;
      inv <= 1'h0;
      inv_d <= 1'h0;
      inv_e <= 1'h0;
    end
    else
    begin
      ca_d <= ca_q;
      pc_d <= pc_q;
      inv_d <= inv;
      inv_e <= inv_d;
      if (acc && pwrite_in && pready_out)
        case (ix)
          12'h209: pc_q <= pwdata_in[3:0];
          12'h20A: ca_q[7:0] <= pwdata_in[7:0];
          12'h20B: ca_q[15:8] <= pwdata_in[7:0];
          12'h20C: ca_q[23:16] <= pwdata_in[7:0];
          12'h210: inv <= pwdata_in[1];
          default: ;
        endcase
    end
  // Correction bits that count in each gray mode
  always_comb
    case (gray_mode_in)
      2'h0: pc_x = pc_q;
      2'h1: pc_x = {1'h0, pc_q[2:0]};
      default: pc_x = {2'h0, pc_q[1:0]};
    endcase
  function automatic logic [31:0] rd_exp(input logic [11:0] i, input logic [3:0] p,
                                         input logic [23:0] a);
    case (i)
      12'h209: rd_exp = {28'h0, p};
      12'h20A: rd_exp = {24'h0, a[7:0]};
      12'h20B: rd_exp = {24'h0, a[15:8]};
      12'h20C: rd_exp = {24'h0, a[23:16]};
      default: rd_exp = 32'h0;
    endcase
  endfunction
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_cursor_follow:
    assert property (ca_q == ca_d |-> cursor_address_bits_out == ca_q)
    else $error("cursor address differs from written value");
  a_pixel_decode:
    assert property (pc_q == pc_d && $stable(gray_mode_in) |-> pixel_offset_bits_out == pc_x)
    else $error("pixel offset decode wrong");
  a_read_back:
    assert property (acc && !pwrite_in && (bad || ix inside {[12'h209:12'h20C]})
      |-> prdata_out == rd_exp(ix, pc_q, ca_q))
    else $error("read data wrong");
  a_err_map:
    assert property (acc |-> pslverr_out == bad)
    else $error("error response wrong");
  a_line_single:
    assert property (line_pulse_out |=> !line_pulse_out)
    else $error("line pulse too long");
  a_frame_single:
    assert property (frame_pulse_out |=> !frame_pulse_out)
    else $error("frame pulse too long");
  a_frame_after_line:
    assert property (frame_pulse_out |-> $past(line_pulse_out))
    else $error("frame pulse without line pulse");
  a_pol_follow:
    assert property (!inv && !inv_d && !inv_e |-> $changed(frame_polarity_out) == frame_pulse_out)
    else $error("polarity not tied to frame pulse");
  c_frame: cover property (frame_pulse_out);
  c_inv_flip: cover property (inv && $changed(frame_polarity_out));
  c_err: cover property (acc && bad);
endmodule
bind lcdft_top lcdft_chk u_lcdft_chk (.*);
`default_nettype wire

// ===== bench/lcdft_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Source clock model
// ------------------------------
module lcdft_src_model
#(
  parameter int OSC_HALF = 3,
  parameter int TMR_HALF = 2
)
(
  input  wire logic sys_clk_in,
  output var  logic osc_out,
  output var  logic tmr_out
);
  int oc = 0;
  int tc = 0;
  // Both run free, so a select switch never waits for a start
  initial osc_out = 1'h0;
  initial tmr_out = 1'h0;
  always @(posedge sys_clk_in)
  begin
    oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
    tc <= (tc == TMR_HALF - 1) ? 0 : tc + 1;
    if (oc == OSC_HALF - 1)
      osc_out <= ~osc_out;
    if (tc == TMR_HALF - 1)
      tmr_out <= ~tmr_out;
  end
endmodule
`default_nettype wire

// ===== bench/lcdft_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bench top
// ------------------------------
module lcdft_top_tb;
  localparam int OH = 3;
  localparam int TH = 2;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        pen = 1'h0;
  logic        pwr = 1'h0;
  logic [13:0] pa = 14'h0;
  logic [31:0] pwd = 32'h0;
  logic [1:0]  gray = 2'h0;
  logic [31:0] prd, rd;
  logic [23:0] ca, v;
  logic [3:0]  po, c;
  logic        rdy, err, e, osc, tmr, lp, fp, pol, p0;
  int          fails = 0;
  int          num_checks = 0;
  int          n, lines, cyc, flips, f;

  lcdft_top u_lcdft_top
  (
    .sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
    .low_freq_osc_in(osc), .timer3_output_in(tmr), .gray_mode_in(gray),
    .cursor_address_bits_out(ca), .pixel_offset_bits_out(po), .line_pulse_out(lp),
    .frame_pulse_out(fp), .frame_polarity_out(pol)
  );
  lcdft_src_model #(.OSC_HALF(OH), .TMR_HALF(TH)) u_lcdft_src_model
    (.sys_clk_in(clk), .osc_out(osc), .tmr_out(tmr));

  initial
    forever #2 clk = ~clk;

  function automatic logic [3:0] dec(input logic [3:0] x, input logic [1:0] g);
    dec = (g == 2'h0) ? x : (g == 2'h1) ? {1'h0, x[2:0]} : {2'h0, x[1:0]};
  endfunction
  // Source edges per line for each common code
  function automatic int d2(input int k);
    d2 = (k == 0) ? 6 : (k == 1) ? 5 : (k == 2) ? 4 : (k < 5) ? 3 : 2;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One transfer; waits on ready, never assumes its latency
  task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    pa <= {i, 2'h0};
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'h1 && n < 50);
    chk(rdy, 1'h1);
    rd = prd;
    e = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  // Cycles, line pulses and polarity flips over one whole frame
  task automatic frame_stats();
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (fp !== 1'h1 && n < 20000);
    lines = 0;
    cyc = 0;
    flips = 0;
    p0 = pol;
    do
    begin
      @(posedge clk);
      cyc++;
      lines += (lp === 1'h1);
      flips += (pol !== p0);
      p0 = pol;
    end
    while (fp !== 1'h1 && cyc < 20000);
    chk(fp, 1'h1);
  endtask

  // First gaps may straddle a setting change, so keep the third
  task automatic line_gap();
    for (int k = 0; k < 3; k++)
    begin
      cyc = 0;
      do
      begin
        @(posedge clk);
        cyc++;
      end
      while (lp !== 1'h1 && cyc < 500);
      chk(lp, 1'h1);
    end
  endtask

  initial
  begin
    void'($urandom(32'h5140));
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h0, 12'h209 + 12'(i), 32'h0);
      chk(rd, (i == 3) ? 32'h40 : 32'h0);
    end
    chk(ca, 24'h400000);
    $display("test reset done");
    repeat (4)
    begin
      v = 24'($urandom);
      apb(1'h1, 12'h20A, {24'h0, v[7:0]});
      apb(1'h1, 12'h20B, {24'h0, v[15:8]});
      apb(1'h1, 12'h20C, {24'h0, v[23:16]});
      repeat (2) @(posedge clk);
      chk(ca, v);
      apb(1'h0, 12'h20B, 32'h0);
      chk(rd, v[15:8]);
    end
    $display("test cursor done");
    for (int g = 0; g < 4; g++)
      for (int k = 0; k < 3; k++)
      begin
        c = (k == 0) ? 4'hE : 4'($urandom);
        // Keep the used bits below the mode's limit
        if (dec(c, 2'(g)) == dec(4'hF, 2'(g)))
          c[0] = 1'h0;
        apb(1'h1, 12'h209, {28'hFFFFFFF, c});
        gray <= 2'(g);
        repeat (3) @(posedge clk);
        chk(po, dec(c, 2'(g)));
        apb(1'h0, 12'h209, 32'h0);
        chk(rd, c);
      end
    $display("test pixel done");
    apb(1'h0, 12'h3FF, 32'h0);
    chk(e, 1'h1);
    chk(rd, 32'h0);
    $display("test map done");
    apb(1'h1, 12'h213, 32'h0);
    apb(1'h1, 12'h210, 32'h0);
    for (int j = 0; j < 2; j++)
    begin
      // Second pass: near 70 Hz from a 32.768 kHz source
      f = (j == 0) ? 128 + ($urandom % 128) : 156;
      apb(1'h1, 12'h211, 32'(f));
      frame_stats();
      chk(lines, f);
      chk(cyc, f * d2(0) * OH);
      chk(flips, 1);
      apb(1'h0, 12'h211, 32'h0);
      chk(rd, f);
    end
    $display("test frame done");
    apb(1'h1, 12'h210, 32'h1);
    apb(1'h1, 12'h211, 32'h0);
    frame_stats();
    chk(lines, 256);
    $display("test count bit done");
    apb(1'h1, 12'h212, 32'h8);
    apb(1'h1, 12'h211, 32'h80);
    apb(1'h1, 12'h210, 32'h2);
    frame_stats();
    chk(lines, 128);
    chk(flips, 16);
    $display("test invert done");
    for (int k = 0; k < 7; k++)
    begin
      apb(1'h1, 12'h213, 32'(k));
      line_gap();
      chk(cyc, d2(k) * OH);
    end
    apb(1'h1, 12'h210, 32'h4);
    line_gap();
    chk(cyc, d2(6) * TH);
    $display("test clock done");
    close_out();
  end

  // Hang guard, well beyond the longest expected run
  initial
  begin
    repeat (80000) @(posedge clk);
    fails++;
    $display("mismatch at %0t: run timed out", $time);
    close_out();
  end
endmodule
`default_nettype wire

// ===== core/lcdft_consts.vh
`ifndef LCDFT_CONSTS_VH
`define LCDFT_CONSTS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define LCDFT_IDX_PIXCORR   12'h209
`define LCDFT_IDX_ADDR_LOW  12'h20A
`define LCDFT_IDX_ADDR_MID  12'h20B
`define LCDFT_IDX_ADDR_HIGH 12'h20C
`define LCDFT_IDX_CONTROL   12'h210
`define LCDFT_IDX_FC_LOW    12'h211
`define LCDFT_IDX_INV_DIV   12'h212
`define LCDFT_IDX_COMMON    12'h213
`define LCDFT_IDX_STATUS    12'h214

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCDFT_RST_PIXCORR   4'h0
`define LCDFT_RST_ADDR_LOW  8'h00
`define LCDFT_RST_ADDR_MID  8'h00
`define LCDFT_RST_ADDR_HIGH 8'h40
`define LCDFT_RST_CONTROL   4'h0
`define LCDFT_RST_FC_LOW    8'h80
`define LCDFT_RST_INV_DIV   8'h00
`define LCDFT_RST_COMMON    3'h0

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define LCDFT_CTL_FC_BIT8   0
`define LCDFT_CTL_INV_EN    1
`define LCDFT_CTL_CLK_SEL   2
`define LCDFT_CTL_FC_BIT9   3

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define LCDFT_STS_POL_BIT   16

// ----------------------------------------
// Gray mode codes
// ----------------------------------------
`define LCDFT_GRAY_MONO     2'h0
`define LCDFT_GRAY_4        2'h1
`define LCDFT_GRAY_8        2'h2
`define LCDFT_GRAY_16       2'h3

// ----------------------------------------
// Source clock edges per line (2 x D) by common code
// ----------------------------------------
`define LCDFT_D2_COM128     3'h6
`define LCDFT_D2_COM160     3'h5
`define LCDFT_D2_COM200     3'h4
`define LCDFT_D2_COM240     3'h3
`define LCDFT_D2_COM320     3'h3
`define LCDFT_D2_COM400     3'h2
`define LCDFT_D2_COM480     3'h2

`endif

// ===== core/lcdft_lpgen.v
`timescale 1ns/1ps
`default_nettype none

module lcdft_lpgen
(
  input  wire       sys_clk_in,
  input  wire       rst_in,
  input  wire       src_level_in,
  input  wire [2:0] edges_per_line_in,
  output reg        line_pulse_out
);

  reg       src_prev;
  reg [2:0] edge_cnt;
  wire      src_edge;

  // Both edges count, so half-integer D stays exact
  assign src_edge = src_level_in ^ src_prev;

  // ----------------------------------------
  // Line pulse every 2 x D source edges
  // ----------------------------------------
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      src_prev       <= 1'b0;
      edge_cnt       <= 3'h0;
      line_pulse_out <= 1'b0;
    end
    else
    begin
      src_prev       <= src_level_in;
      line_pulse_out <= 1'b0;
      if (src_edge)
      begin
        if (edge_cnt + 3'h1 >= edges_per_line_in)
        begin
          edge_cnt       <= 3'h0;
          line_pulse_out <= 1'b1;
        end
        else
        begin
          edge_cnt <= edge_cnt + 3'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== core/lcdft_sync.v
`timescale 1ns/1ps
`default_nettype none

module lcdft_sync
#(
  parameter WIDTH = 2
)
(
  input  wire             sys_clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ----------------------------------------
  // Two-stage synchroniser, one per bit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg stage1;
      reg stage2;
      // First stage feeds only the second
      always @(posedge sys_clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end
        else
        begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== core/lcdft_top.v
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "lcdft_consts.vh"

module lcdft_top
(
  input  wire        sys_clk_in,
  input  wire        rst_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [13:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output reg         pslverr_out,
  // Source clock candidates
  input  wire        low_freq_osc_in,
  input  wire        timer3_output_in,
  // From the rest of the controller
  input  wire [1:0]  gray_mode_in,
  // Cursor hot point
  output reg  [23:0] cursor_address_bits_out,
  output reg  [3:0]  pixel_offset_bits_out,
  // Panel timing
  output wire        line_pulse_out,
  output reg         frame_pulse_out,
  output reg         frame_polarity_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [3:0]  pix_corr;
  reg  [7:0]  addr_low;
  reg  [7:0]  addr_mid;
  reg  [7:0]  addr_high;
  reg  [3:0]  ctl;
  reg  [7:0]  fc_low;
  reg  [7:0]  inv_div;
  reg  [2:0]  common_sel;

  reg  [9:0]  line_cnt;
  reg  [7:0]  inv_cnt;

  wire [11:0] idx;
  wire        setup_phase;
  wire        wr_access;
  reg         idx_mapped;
  reg  [31:0] next_rdata;

  wire [9:0]  frame_count;
  wire [9:0]  frame_last;
  wire [7:0]  inv_last;
  wire        frame_end;
  wire        inv_end;
  wire        frame_inv_en;

  wire [1:0]  src_sync;
  wire        src_level;
  reg  [2:0]  edges_per_line;
  reg  [3:0]  next_pix_shift;

  // ----------------------------------------
  // Register map, word index and kept bits
  // ----------------------------------------
  // 0x209: correction, bits 3:0
  // 0x20A, 0x20B, 0x20C: cursor address low, mid, high
  // 0x210: count bit 8, invert enable, source select, count bit 9
  // 0x211: frame count bits 7:0
  // 0x212: invert divider, zero stands for 256 lines
  // 0x213: common select, codes 0 to 6, code 7 as the last
  // 0x214: status, read only; line count and polarity
  // Unmapped words answer with an error and read zero
  // Writes to the status word are dropped, not refused

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Word index; byte lanes below it are ignored
  assign idx         = paddr_in[13:2];
  assign setup_phase = psel_in & ~penable_in;
  assign wr_access   = psel_in & penable_in & pwrite_in & ~pslverr_out;

  // Zero wait states: read data is staged in setup
  assign pready_out  = 1'b1;

  // Address map check
  always @*
  begin
    case (idx)
      `LCDFT_IDX_PIXCORR,
      `LCDFT_IDX_ADDR_LOW,
      `LCDFT_IDX_ADDR_MID,
      `LCDFT_IDX_ADDR_HIGH,
      `LCDFT_IDX_CONTROL,
      `LCDFT_IDX_FC_LOW,
      `LCDFT_IDX_INV_DIV,
      `LCDFT_IDX_COMMON,
      `LCDFT_IDX_STATUS:
        idx_mapped = 1'b1;
      default:
        idx_mapped = 1'b0;
    endcase
  end

  // Read multiplexer; unused upper bits read zero
  always @*
  begin
    next_rdata = 32'h00000000;
    case (idx)
      `LCDFT_IDX_PIXCORR:   next_rdata[3:0] = pix_corr;
      `LCDFT_IDX_ADDR_LOW:  next_rdata[7:0] = addr_low;
      `LCDFT_IDX_ADDR_MID:  next_rdata[7:0] = addr_mid;
      `LCDFT_IDX_ADDR_HIGH: next_rdata[7:0] = addr_high;
      `LCDFT_IDX_CONTROL:   next_rdata[3:0] = ctl;
      `LCDFT_IDX_FC_LOW:    next_rdata[7:0] = fc_low;
      `LCDFT_IDX_INV_DIV:   next_rdata[7:0] = inv_div;
      `LCDFT_IDX_COMMON:    next_rdata[2:0] = common_sel;
      `LCDFT_IDX_STATUS:
      begin
        next_rdata[9:0]                 = line_cnt;
        next_rdata[`LCDFT_STS_POL_BIT] = frame_polarity_out;
      end
      default:              next_rdata = 32'h00000000;
    endcase
  end

  // Read data and error latched in the setup cycle
  // Staging here keeps the read mux off the prdata path
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_out  <= pwrite_in ? 32'h00000000 : next_rdata;
      pslverr_out <= ~idx_mapped;
    end
    else if (~psel_in)
    begin
      pslverr_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Only the low nibble of the correction byte is kept
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pix_corr   <= `LCDFT_RST_PIXCORR;
      addr_low   <= `LCDFT_RST_ADDR_LOW;
      addr_mid   <= `LCDFT_RST_ADDR_MID;
      addr_high  <= `LCDFT_RST_ADDR_HIGH;
      ctl        <= `LCDFT_RST_CONTROL;
      fc_low     <= `LCDFT_RST_FC_LOW;
      inv_div    <= `LCDFT_RST_INV_DIV;
      common_sel <= `LCDFT_RST_COMMON;
    end
    else if (wr_access)
    begin
      case (idx)
        `LCDFT_IDX_PIXCORR:   pix_corr   <= pwdata_in[3:0];
        `LCDFT_IDX_ADDR_LOW:  addr_low   <= pwdata_in[7:0];
        `LCDFT_IDX_ADDR_MID:  addr_mid   <= pwdata_in[7:0];
        `LCDFT_IDX_ADDR_HIGH: addr_high  <= pwdata_in[7:0];
        `LCDFT_IDX_CONTROL:   ctl        <= pwdata_in[3:0];
        `LCDFT_IDX_FC_LOW:    fc_low     <= pwdata_in[7:0];
        `LCDFT_IDX_INV_DIV:   inv_div    <= pwdata_in[7:0];
        `LCDFT_IDX_COMMON:    common_sel <= pwdata_in[2:0];
        default:              pix_corr   <= pix_corr;
      endcase
    end
  end

  // ----------------------------------------
  // Cursor hot point
  // ----------------------------------------
  // Correction width narrows as pixels get wider in memory
  // Upper bits dropped here, not at write, so readback
  // returns the nibble that software wrote
  always @*
  begin
    case (gray_mode_in)
      `LCDFT_GRAY_MONO: next_pix_shift = pix_corr;
      `LCDFT_GRAY_4:    next_pix_shift = {1'b0, pix_corr[2:0]};
      `LCDFT_GRAY_8:    next_pix_shift = {2'b00, pix_corr[1:0]};
      `LCDFT_GRAY_16:   next_pix_shift = {2'b00, pix_corr[1:0]};
      default:          next_pix_shift = 4'h0;
    endcase
  end

  // Registered so the address stream sees a stable pair
  // Byte writes are not atomic; write the high byte last
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cursor_address_bits_out <= {`LCDFT_RST_ADDR_HIGH, `LCDFT_RST_ADDR_MID,
                                  `LCDFT_RST_ADDR_LOW};
      pixel_offset_bits_out   <= 4'h0;
    end
    else
    begin
      cursor_address_bits_out <= {addr_high, addr_mid, addr_low};
      pixel_offset_bits_out   <= next_pix_shift;
    end
  end

  // ----------------------------------------
  // Source clock selection
  // ----------------------------------------
  // Both candidates come from outside this clock domain
  lcdft_sync
  #(
    .WIDTH (2)
  )
  u_src_sync
  (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({timer3_output_in, low_freq_osc_in}),
    .sync_out   (src_sync)
  );

  // Switching source may cost one stray edge; harmless
  // Both candidates stay synchronised, so a switch needs
  // no settling time beyond one line
  assign src_level = ctl[`LCDFT_CTL_CLK_SEL] ? src_sync[1] : src_sync[0];

  // ----------------------------------------
  // Line pulse generation
  // ----------------------------------------
  // Constant D per panel common count, doubled to stay integral
  // Unused code 7 falls back to the shortest line
  always @*
  begin
    case (common_sel)
      3'h0:    edges_per_line = `LCDFT_D2_COM128;
      3'h1:    edges_per_line = `LCDFT_D2_COM160;
      3'h2:    edges_per_line = `LCDFT_D2_COM200;
      3'h3:    edges_per_line = `LCDFT_D2_COM240;
      3'h4:    edges_per_line = `LCDFT_D2_COM320;
      3'h5:    edges_per_line = `LCDFT_D2_COM400;
      3'h6:    edges_per_line = `LCDFT_D2_COM480;
      default: edges_per_line = `LCDFT_D2_COM480;
    endcase
  end

  // Edge count survives a common change, so the first
  // line after it may come short; later lines are exact
  lcdft_lpgen u_lpgen
  (
    .sys_clk_in        (sys_clk_in),
    .rst_in            (rst_in),
    .src_level_in      (src_level),
    .edges_per_line_in (edges_per_line),
    .line_pulse_out    (line_pulse_out)
  );

  // ----------------------------------------
  // Frame counter
  // ----------------------------------------
  // A count of zero wraps to 1024 lines
  // Lowering the count mid-frame below the lines already counted ends it at the next line
  assign frame_count = {ctl[`LCDFT_CTL_FC_BIT9], ctl[`LCDFT_CTL_FC_BIT8],
                        fc_low};
  assign frame_last  = frame_count - 10'h001;
  assign frame_end   = line_pulse_out & (line_cnt >= frame_last);

  // Ends a frame after frame_count line pulses
  // Frame pulse trails its line pulse by one clock
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      line_cnt        <= 10'h000;
      frame_pulse_out <= 1'b0;
    end
    else
    begin
      frame_pulse_out <= frame_end;
      if (frame_end)
      begin
        line_cnt <= 10'h000;
      end
      else if (line_pulse_out)
      begin
        line_cnt <= line_cnt + 10'h001;
      end
    end
  end

  // ----------------------------------------
  // Frame polarity
  // ----------------------------------------
  // Divider only steers polarity, never the frame pulse
  assign frame_inv_en = ctl[`LCDFT_CTL_INV_EN];
  assign inv_last     = inv_div - 8'h01;
  assign inv_end      = line_pulse_out & (inv_cnt >= inv_last);

  // Own line counter, independent of the frame counter
  // Held at zero while disabled, so enabling starts a full
  // run of N lines and the first toggle never comes early
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      inv_cnt            <= 8'h00;
      frame_polarity_out <= 1'b0;
    end
    else if (frame_inv_en)
    begin
      if (inv_end)
      begin
        inv_cnt            <= 8'h00;
        frame_polarity_out <= ~frame_polarity_out;
      end
      else if (line_pulse_out)
      begin
        inv_cnt <= inv_cnt + 8'h01;
      end
    end
    else
    begin
      inv_cnt <= 8'h00;
      if (frame_end)
      begin
        frame_polarity_out <= ~frame_polarity_out;
      end
    end
  end

endmodule

`default_nettype wire
